// [membus_pkg.sv]
/*
 * Shared constants and types for the processor memory-bus pin model.
 * Assumes both ends run on the same mclk_i at 200 MHz.
 */
package membus_pkg;
	// Number of byte lanes on the data bus.
	localparam int unsigned LANES       = 4;
	// Width of the test input bus.
	localparam int unsigned TEST_IN_W   = 8;
	// Width of the test output bus.
	localparam int unsigned TEST_OUT_W  = 3;
	// Width of the address generated by the core.
	localparam int unsigned ADDR_W      = 32;
	// Address fetched after reset release.
	localparam logic [31:0] RESET_ADDR  = 32'h0000_0000;
	// Least reset hold, in memory clock cycles.
	localparam int unsigned RESET_MIN_MCLK = 5;
	// Counter width for the reset hold counter.
	localparam int unsigned RESET_CNT_W = 3;
	// Reset value of the byte lane selects (no lane selected).
	localparam logic [3:0]  BLS_IDLE    = 4'hf;
	// Full-word lane selects (all lanes selected).
	localparam logic [3:0]  BLS_WORD    = 4'h0;

	// Kind of access requested by the user side of the core.
	typedef enum logic [1:0]
	{
		ACC_IDLE,
		ACC_READ,
		ACC_WRITE
	} access_t;

	// Core bus sequencer states.
	typedef enum logic [1:0]
	{
		ST_RESET,
		ST_IDLE,
		ST_ACCESS,
		ST_STALL
	} bus_state_t;
endpackage : membus_pkg

// [membus_if.sv]
/*
 * Interface joining the processor end and the memory system end.
 * Assumes a single clock shared by both parties.
 */
`timescale 1ns/10ps
`default_nettype none
interface membus_if;
	import membus_pkg::*;
	logic [3:0]            byte_lane_select_n;     // Active-low lane selects.
	logic                  byte_not_word;          // High word, low byte.
	logic                  write_not_read;         // High write, low read.
	logic                  data_out_enable_n;      // Low while writing.
	logic                  mem_request_n;          // Low: access next cycle.
	logic                  sequential_cycle;       // Inverse of request.
	logic [ADDR_W-1:0]     address;                // Access address.
	logic [31:0]           data_out;               // Write data.
	logic [31:0]           data_in;                // Read data.
	logic                  address_latch_en;       // Low holds address phase.
	logic                  data_bus_enable;        // Low forces data off bus.
	logic                  stall_request_n;        // Low inserts wait cycles.
	logic                  fast_irq_n;             // Fast interrupt, low.
	logic                  normal_interrupt_req_n; // Normal interrupt, low.
	logic                  chip_reset_n;           // Core reset, low.
	logic                  high_speed_bus_select;  // High selects fast bus.
	logic                  sync_not_async_select;  // Clocking relation.
	logic [TEST_IN_W-1:0]  test_input_bus;         // Test inputs.
	logic [TEST_OUT_W-1:0] test_output_bus;        // Test outputs.

	// The processor end.
	modport cpu
	(
		output byte_lane_select_n, byte_not_word, write_not_read,
		output data_out_enable_n, mem_request_n, sequential_cycle,
		output address, data_out, test_output_bus,
		input  data_in, address_latch_en, data_bus_enable, stall_request_n,
		input  fast_irq_n, normal_interrupt_req_n, chip_reset_n,
		input  high_speed_bus_select, sync_not_async_select, test_input_bus
	);

	// The memory system end.
	modport mem
	(
		input  byte_lane_select_n, byte_not_word, write_not_read,
		input  data_out_enable_n, mem_request_n, sequential_cycle,
		input  address, data_out, test_output_bus,
		output data_in, address_latch_en, data_bus_enable, stall_request_n,
		output fast_irq_n, normal_interrupt_req_n, chip_reset_n,
		output high_speed_bus_select, sync_not_async_select, test_input_bus
	);
endinterface : membus_if
`default_nettype wire

// [membus_cpu.sv]
/*
 * Processor end of the memory bus: request pipeline, address phase
 * latches, byte lanes, data-out enable, interrupt sampling and reset.
 * Assumes the memory end keeps its own obligations on stall and reset.
 */
`timescale 1ns/10ps
`default_nettype none
module membus_cpu
(
	input  wire logic                         mclk_i,
	input  wire logic                         reset_n_i,
	input  wire logic                         clk_en_i,
	membus_if.cpu                             bus,
	input  wire membus_pkg::access_t          req_kind_i,
	input  wire logic                         req_byte_i,
	input  wire logic [membus_pkg::ADDR_W-1:0] req_addr_i,
	input  wire logic [31:0]                  req_wdata_i,
	input  wire logic                         fiq_enable_i,
	input  wire logic                         irq_enable_i,
	output logic                              req_ready_o,
	output logic                              rd_valid_o,
	output logic [31:0]                       rd_data_o,
	output logic                              fiq_take_o,
	output logic                              irq_take_o,
	output logic                              units_enable_o,
	output logic                              sync_mode_o
);
	import membus_pkg::*;

	bus_state_t        state_q, state_d;       // Sequencer state.
	logic              mreq_n_q;               // Pipelined request.
	access_t           kind_q;                 // Access due on the bus next cycle.
	logic              byte_q;                 // Byte access flag.
	logic [ADDR_W-1:0] addr_q;                 // Address of the access.
	logic [31:0]       wdata_q;                // Write data held.
	access_t           bus_kind_q;             // Access now shown on the bus.
	logic [31:0]       dout_q;                 // Write data shown on the bus.
	logic              rd_pend_q;              // Read data is due next edge.
	logic [3:0]        lanes_q;                // Lane selects before latch.
	logic [3:0]        lanes_lat_q;            // Lane selects after latch.
	logic              bw_lat_q;               // byte_not_word after latch.
	logic              wr_lat_q;               // write_not_read after latch.
	logic [ADDR_W-1:0] addr_lat_q;             // Address after latch.
	logic [2:0]        rst_sync_q;             // Reset pin sampler.
	logic [2:0]        fiq_sync_q;             // Fast interrupt sampler.
	logic [2:0]        irq_sync_q;             // Normal interrupt sampler.
	logic [2:0]        wait_sync_q;            // Stall pin sampler.
	logic              rd_valid_q;             // Read data strobe.
	logic [31:0]       rd_data_q;              // Captured read data.
	logic              units_q;                // Cache, MMU, buffer on.
	logic              sync_q;                 // Resolved clocking mode.

	// A pin is believed low once the two later sampler stages agree.
	wire core_reset   = !rst_sync_q[1] && !rst_sync_q[2];
	wire fiq_low      = !fiq_sync_q[1] && !fiq_sync_q[2];
	wire irq_low      = !irq_sync_q[1] && !irq_sync_q[2];
	wire stall_low    = !wait_sync_q[1] && !wait_sync_q[2];
	wire want_access  = (req_kind_i != ACC_IDLE);
	// A request is taken only while ready is shown, never under a stall.
	wire take         = want_access && req_ready_o;
	// The bus stage freezes under a stall, so the access on it is stretched.
	wire bus_step     = clk_en_i && (!stall_low || core_reset);
	wire is_write     = (bus_kind_q == ACC_WRITE);
	wire [3:0] lanes_next = req_byte_i ?
		~(4'h1 << req_addr_i[1:0]) : BLS_WORD;

	// Synchronise pins through three flops each.
	// reset, interrupt and stall synchronisers
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_sync_q  <= 3'h0;
			fiq_sync_q  <= 3'h7;
			irq_sync_q  <= 3'h7;
			wait_sync_q <= 3'h7;
		end
		else if (clk_en_i)
		begin
			rst_sync_q  <= {rst_sync_q[1:0], bus.chip_reset_n};
			fiq_sync_q  <= {fiq_sync_q[1:0], bus.fast_irq_n};
			irq_sync_q  <= {irq_sync_q[1:0], bus.normal_interrupt_req_n};
			wait_sync_q <= {wait_sync_q[1:0], bus.stall_request_n};
		end
	end

	// Next state: reset beats everything, a stall holds the access.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RESET:  state_d = ST_IDLE;
			ST_IDLE:   state_d = take ? ST_ACCESS : ST_IDLE;
			ST_ACCESS: state_d = stall_low ? ST_STALL :
				(take ? ST_ACCESS : ST_IDLE);
			ST_STALL:  state_d = stall_low ? ST_STALL :
				(take ? ST_ACCESS : ST_IDLE);
			default:   state_d = ST_RESET;
		endcase
		if (core_reset)
			state_d = ST_RESET;
	end

	// Sequencer, request pipeline and address phase.
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q  <= ST_RESET;
			mreq_n_q <= 1'b1;
			kind_q   <= ACC_IDLE;
			byte_q   <= 1'b0;
			addr_q   <= RESET_ADDR;
			wdata_q  <= 32'h0;
			lanes_q  <= BLS_IDLE;
			units_q  <= 1'b0;
		end
		else if (clk_en_i)
		begin
			state_q <= state_d;
			if (core_reset)
			begin
				mreq_n_q <= 1'b1;
				kind_q   <= ACC_IDLE;
				lanes_q  <= BLS_IDLE;
				addr_q   <= addr_q + 32'h4;
				units_q  <= 1'b0;
			end
			else if (state_q == ST_RESET)
			begin
				addr_q <= RESET_ADDR;
			end
			else if (!stall_low)
			begin
				mreq_n_q <= !take;
				kind_q   <= take ? req_kind_i : ACC_IDLE;
				lanes_q  <= take ? lanes_next : BLS_IDLE;
				// Only a taken request may replace the held access.
				if (take)
				begin
					byte_q  <= req_byte_i;
					addr_q  <= req_addr_i;
					wdata_q <= req_wdata_i;
				end
			end
		end
	end

	// Registered address phase, held while the latch enable is low.
	// latch-held lane update
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			lanes_lat_q <= BLS_IDLE;
			bw_lat_q    <= 1'b1;
			wr_lat_q    <= 1'b0;
			addr_lat_q  <= RESET_ADDR;
			bus_kind_q  <= ACC_IDLE;
			dout_q      <= 32'h0;
		end
		else if (bus_step)
		begin
			bus_kind_q <= core_reset ? ACC_IDLE : kind_q;
			dout_q     <= wdata_q;
			if (bus.address_latch_en)
			begin
				lanes_lat_q <= lanes_q;
				bw_lat_q    <= !byte_q;
				wr_lat_q    <= (kind_q == ACC_WRITE);
				addr_lat_q  <= addr_q;
			end
		end
	end

	// Read capture, interrupt decisions and mode resolution.
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rd_pend_q  <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q  <= 32'h0;
			fiq_take_o <= 1'b0;
			irq_take_o <= 1'b0;
			sync_q     <= 1'b0;
		end
		else if (clk_en_i)
		begin
			// The memory registers its answer, so read data lags the bus cycle by one edge.
			rd_pend_q  <= bus_step && !core_reset && (bus_kind_q == ACC_READ);
			rd_valid_q <= rd_pend_q;
			if (rd_pend_q)
				rd_data_q <= bus.data_in;
			fiq_take_o <= fiq_enable_i && fiq_low && !core_reset;
			irq_take_o <= irq_enable_i && irq_low && !(fiq_enable_i && fiq_low) &&
				!core_reset;
			if (!bus.high_speed_bus_select)
				sync_q <= bus.sync_not_async_select;
		end
	end

	assign bus.byte_lane_select_n = lanes_lat_q;
	assign bus.byte_not_word      = bw_lat_q;
	assign bus.write_not_read     = wr_lat_q;
	assign bus.address            = addr_lat_q;
	assign bus.data_out           = dout_q;
	assign bus.data_out_enable_n  = !(is_write && bus.data_bus_enable);
	assign bus.mem_request_n      = mreq_n_q;
	assign bus.sequential_cycle   = !mreq_n_q;
	assign bus.test_output_bus    = (bus.test_input_bus == 8'h00) ? 3'h0 :
		bus.test_input_bus[2:0];

	assign req_ready_o    = !core_reset && (state_q != ST_RESET) && !stall_low;
	assign rd_valid_o     = rd_valid_q;
	assign rd_data_o      = rd_data_q;
	assign units_enable_o = units_q;
	assign sync_mode_o    = sync_q;
endmodule : membus_cpu
`default_nettype wire

// [membus_mem.sv]
/*
 * Memory system end: small word memory, stall generation, reset
 * sequencing and strap pins for the processor end.
 * Assumes the processor end drives the bus on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module membus_mem
(
	input  wire logic                         mclk_i,
	input  wire logic                         reset_n_i,
	input  wire logic                         clk_en_i,
	membus_if.mem                             bus,
	input  wire logic                         sys_reset_req_i,
	input  wire logic                         stall_req_i,
	input  wire logic                         fiq_raise_i,
	input  wire logic                         fiq_ack_i,
	input  wire logic                         irq_level_i,
	input  wire logic                         high_speed_i,
	input  wire logic                         sync_sel_i,
	input  wire logic                         data_bus_en_i,
	input  wire logic                         latch_en_i,
	output logic                              reset_active_o,
	output logic [membus_pkg::TEST_OUT_W-1:0] test_seen_o
);
	import membus_pkg::*;

	wire  [31:0]            word_rd;         // Word read from all lanes.
	logic [31:0]            rdata_q;         // Read data register.
	logic [RESET_CNT_W-1:0] rst_cnt_q;       // Reset hold counter.
	logic                   rst_n_q;         // Driven core reset.
	logic                   fiq_n_q;         // Held fast interrupt.
	logic                   wait_n_q;        // Driven stall.

	wire [3:0] widx      = bus.address[5:2];
	wire       hold_done = (rst_cnt_q == RESET_CNT_W'(RESET_MIN_MCLK));

	// Reset hold, stall and fast interrupt generation.
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_cnt_q <= '0;
			rst_n_q   <= 1'b0;
			fiq_n_q   <= 1'b1;
			wait_n_q  <= 1'b1;
		end
		else if (clk_en_i)
		begin
			if (sys_reset_req_i || !rst_n_q)
			begin
				rst_n_q   <= sys_reset_req_i ? 1'b0 : hold_done;
				rst_cnt_q <= sys_reset_req_i ? '0 :
					(hold_done ? rst_cnt_q : rst_cnt_q + RESET_CNT_W'(1));
			end
			wait_n_q <= !(stall_req_i && rst_n_q && !sys_reset_req_i);
			if (fiq_raise_i)
				fiq_n_q <= 1'b0;
			else if (fiq_ack_i)
				fiq_n_q <= 1'b1;
		end
	end

	// Word memory with byte-lane writes, one generate slice per lane.
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			// Each lane owns its byte store, so no two processes write one array.
			logic [7:0] lane_q [0:15];
			always_ff @(posedge mclk_i)
			begin
				if (clk_en_i && !bus.data_out_enable_n && !bus.byte_lane_select_n[g])
					lane_q[widx] <= bus.data_out[8*g +: 8];
			end
			assign word_rd[8*g +: 8] = lane_q[widx];
		end
	endgenerate

	// Read data is registered so it is stable before the sampling edge.
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_q <= 32'h0;
		else if (clk_en_i)
			rdata_q <= word_rd;
	end

	assign bus.data_in                = rdata_q;
	assign bus.chip_reset_n           = rst_n_q;
	assign bus.stall_request_n        = wait_n_q;
	assign bus.fast_irq_n             = fiq_n_q;
	assign bus.normal_interrupt_req_n = !irq_level_i;
	assign bus.high_speed_bus_select  = high_speed_i;
	assign bus.sync_not_async_select  = sync_sel_i;
	assign bus.test_input_bus         = 8'h00;
	assign bus.data_bus_enable        = data_bus_en_i;
	assign bus.address_latch_en       = latch_en_i;
	assign reset_active_o             = !rst_n_q;
	assign test_seen_o                = bus.test_output_bus;
endmodule : membus_mem
`default_nettype wire

// [membus_monitor.sv]
/*
 * Concurrent checks on the wires between the processor end and the memory end.
 * Assumes one clock, mclk_i, and the bench's asynchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module membus_monitor
(
	input wire logic                              mclk_i,
	input wire logic                              reset_n_i,
	input wire logic [3:0]                        byte_lane_select_n,
	input wire logic                              byte_not_word,
	input wire logic                              write_not_read,
	input wire logic                              data_out_enable_n,
	input wire logic                              mem_request_n,
	input wire logic                              sequential_cycle,
	input wire logic [membus_pkg::ADDR_W-1:0]     address,
	input wire logic                              address_latch_en,
	input wire logic                              data_bus_enable,
	input wire logic                              stall_request_n,
	input wire logic                              chip_reset_n,
	input wire logic [membus_pkg::TEST_IN_W-1:0]  test_input_bus,
	input wire logic [membus_pkg::TEST_OUT_W-1:0] test_output_bus
);
	import membus_pkg::*;

	// Every check lives in the one clock domain.
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	seq_inverse_a: assert property (sequential_cycle == !mem_request_n)
		else $error("sequential_cycle is not the inverse of mem_request_n");
	oe_forced_a: assert property (!data_bus_enable |-> data_out_enable_n)
		else $error("data out enabled while data bus enable is low");
	oe_write_a: assert property ((!data_out_enable_n && address_latch_en) |-> write_not_read)
		else $error("data out enabled outside a write");
	word_lanes_a: assert property ((byte_not_word && byte_lane_select_n != BLS_IDLE)
		|-> byte_lane_select_n == BLS_WORD)
		else $error("word access without all lanes selected");
	byte_lane_a: assert property ((!byte_not_word && byte_lane_select_n != BLS_IDLE)
		|-> $onehot(~byte_lane_select_n))
		else $error("byte access selects more than one lane");
	// A held latch must freeze the whole address phase, not only the address.
	latch_hold_a: assert property ((!address_latch_en && $past(!address_latch_en))
		|-> $stable({address, byte_lane_select_n, byte_not_word, write_not_read}))
		else $error("address phase moved while latch enable low");
	test_low_a: assert property ((test_input_bus == '0) |-> (test_output_bus == '0))
		else $error("test outputs not low with test inputs low");
	reset_idle_a: assert property (!chip_reset_n [*5] |-> mem_request_n)
		else $error("memory request during core reset");
	// Six cycles leave room for the stall synchroniser to settle.
	stall_hold_a: assert property (!stall_request_n [*6]
		|-> $stable({address, byte_lane_select_n}))
		else $error("address phase moved during a stall");

	// Main scenarios reached.
	cover property (!data_out_enable_n);
	cover property (!stall_request_n && !mem_request_n);
	cover property (!byte_not_word && byte_lane_select_n != BLS_IDLE);
endmodule : membus_monitor
`default_nettype wire

// [testbench.sv]
/*
 * Self-checking bench: both ends joined by membus_if, a memory model kept in arrays.
 * Assumes the memory end indexes its 16 words by address bits 5 to 2.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import membus_pkg::*;
	logic              mclk_i = 1'b0;          // 200 MHz clock.
	logic              reset_n_i = 1'b0;       // Held low at start.
	logic              clk_en_i = 1'b1;        // Always running.
	access_t           req_kind_i = ACC_IDLE;  // User request.
	logic              req_byte_i = 1'b0;
	logic [ADDR_W-1:0] req_addr_i = 32'h0;
	logic [31:0]       req_wdata_i = 32'h0;
	logic              fiq_enable_i = 1'b1;
	logic              irq_enable_i = 1'b1;
	logic              sys_reset_req_i = 1'b0;
	logic              stall_req_i = 1'b0;
	logic              fiq_raise_i = 1'b0;
	logic              fiq_ack_i = 1'b0;
	logic              irq_level_i = 1'b0;
	logic              high_speed_i = 1'b0;
	logic              sync_sel_i = 1'b0;
	logic              data_bus_en_i = 1'b1;
	logic              latch_en_i = 1'b1;
	logic              req_ready_o, rd_valid_o, fiq_take_o, irq_take_o;
	logic              units_enable_o, sync_mode_o, reset_active_o;
	logic [31:0]       rd_data_o;
	logic [2:0]        test_seen_o;
	logic [5:0]        obs_q = 6'h3f;          // Last lanes, width and direction seen.
	logic [31:0]       model_q [16];           // Expected memory contents.
	bit                known_q [16];           // Word written by the bench.
	logic [3:0]        idx;
	logic [31:0]       a, d, r;
	logic              wr, bsel;
	int                n_mismatch = 0;
	int                cmp_count = 0;

	membus_if bus_if();

	membus_cpu membus_cpu_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
		.bus(bus_if), .req_kind_i(req_kind_i), .req_byte_i(req_byte_i), .req_addr_i(req_addr_i),
		.req_wdata_i(req_wdata_i), .fiq_enable_i(fiq_enable_i), .irq_enable_i(irq_enable_i),
		.req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
		.fiq_take_o(fiq_take_o), .irq_take_o(irq_take_o), .units_enable_o(units_enable_o),
		.sync_mode_o(sync_mode_o));

	membus_mem membus_mem_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
		.bus(bus_if), .sys_reset_req_i(sys_reset_req_i), .stall_req_i(stall_req_i),
		.fiq_raise_i(fiq_raise_i), .fiq_ack_i(fiq_ack_i), .irq_level_i(irq_level_i),
		.high_speed_i(high_speed_i), .sync_sel_i(sync_sel_i), .data_bus_en_i(data_bus_en_i),
		.latch_en_i(latch_en_i), .reset_active_o(reset_active_o), .test_seen_o(test_seen_o));

	membus_monitor membus_monitor_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.byte_lane_select_n(bus_if.byte_lane_select_n), .byte_not_word(bus_if.byte_not_word),
		.write_not_read(bus_if.write_not_read), .data_out_enable_n(bus_if.data_out_enable_n),
		.mem_request_n(bus_if.mem_request_n), .sequential_cycle(bus_if.sequential_cycle),
		.address(bus_if.address), .address_latch_en(bus_if.address_latch_en),
		.data_bus_enable(bus_if.data_bus_enable), .stall_request_n(bus_if.stall_request_n),
		.chip_reset_n(bus_if.chip_reset_n), .test_input_bus(bus_if.test_input_bus),
		.test_output_bus(bus_if.test_output_bus));

	// Free-running clock, 5 ns period.
	always #2.5 mclk_i = ~mclk_i;

	// Remember the address phase of the latest access for later comparison.
	always @(posedge mclk_i)
	begin
		if (bus_if.byte_lane_select_n !== BLS_IDLE)
			obs_q <= {bus_if.byte_lane_select_n, bus_if.byte_not_word, bus_if.write_not_read};
	end

	task check_data(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_data

	task check_bit(input logic got, input logic exp);
		check_data({31'h0, got}, {31'h0, exp});
	endtask : check_bit

	// Hold the request until ready was seen, then wait for read data or the bus phase.
	task do_acc(input access_t kind, input logic b, input logic [31:0] ad, input logic [31:0] wd);
		int n;
		@(posedge mclk_i);
		#1;
		req_kind_i = kind;
		req_byte_i = b;
		req_addr_i = ad;
		req_wdata_i = wd;
		n = 0;
		@(negedge mclk_i);
		while (req_ready_o !== 1'b1 && n < 100)
		begin
			@(negedge mclk_i);
			n++;
		end
		@(posedge mclk_i);
		#1;
		req_kind_i = ACC_IDLE;
		while (kind == ACC_READ && rd_valid_o !== 1'b1 && n < 140)
		begin
			@(negedge mclk_i);
			n++;
		end
		// A run-out of either wait counts against the design.
		if (n >= 100)
			n_mismatch++;
		repeat (3) @(negedge mclk_i);
		// Return just after a rising edge so the caller's changes keep the stimulus delay.
		@(posedge mclk_i);
		#1;
	endtask : do_acc

	// Change inputs 1 ns after a rising edge, then let cycles pass.
	task step(input int cycles);
		repeat (cycles) @(negedge mclk_i);
		@(posedge mclk_i);
		#1;
	endtask : step

	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// Watchdog: the tests need well under 2000 cycles.
	initial
	begin
		#20000;
		n_mismatch++;
		give_verdict();
	end

	initial
	begin
		void'($urandom(15));
		repeat (4) @(posedge mclk_i);
		#1;
		reset_n_i = 1'b1;
		// Random traffic; the first eight are writes so reads find known words.
		for (int i = 0; i < 24; i++)
		begin
			idx = 4'($urandom);
			d = $urandom;
			r = $urandom;
			wr = (i < 8) || r[2];
			bsel = !wr && r[3];
			a = {26'h0, idx, bsel ? r[1:0] : 2'b00};
			do_acc(wr ? ACC_WRITE : ACC_READ, bsel, a, d);
			check_data({26'h0, obs_q}, {26'h0, bsel ? ~(4'h1 << a[1:0]) : BLS_WORD, !bsel, wr});
			if (wr)
			begin
				model_q[idx] = d;
				known_q[idx] = 1'b1;
			end
			else if (known_q[idx])
				check_data(rd_data_o, model_q[idx]);
		end
		// Word 15 gets a known value; a write with the data bus disabled must not land.
		do_acc(ACC_WRITE, 1'b0, 32'h3c, 32'hc3c3_3c3c);
		model_q[15] = 32'hc3c3_3c3c;
		known_q[15] = 1'b1;
		data_bus_en_i = 1'b0;
		do_acc(ACC_WRITE, 1'b0, 32'h3c, 32'h5a5a_a5a5);
		data_bus_en_i = 1'b1;
		do_acc(ACC_READ, 1'b0, 32'h3c, 32'h0);
		check_data(rd_data_o, model_q[15]);
		// Stall: requests are refused, then a read is taken in a gap, and a stall raised with it stretches the read until that stall clears.
		stall_req_i = 1'b1;
		step(8);
		check_bit(req_ready_o, 1'b0);
		stall_req_i = 1'b0;
		fork
			do_acc(ACC_READ, 1'b0, 32'h3c, 32'h0);
			begin
				// Stall raised with the read request; the core sees it while the read is on the bus, so the read data is captured only after the stall clears.
				step(0);
				stall_req_i = 1'b1;
				step(8);
				stall_req_i = 1'b0;
			end
		join
		check_data(rd_data_o, model_q[15]);
		// Fast interrupt beats normal, ack clears it, enables gate both.
		irq_level_i = 1'b1;
		fiq_raise_i = 1'b1;
		step(0);
		fiq_raise_i = 1'b0;
		step(8);
		check_bit(fiq_take_o, 1'b1);
		check_bit(irq_take_o, 1'b0);
		fiq_ack_i = 1'b1;
		step(0);
		fiq_ack_i = 1'b0;
		step(8);
		check_bit(fiq_take_o, 1'b0);
		check_bit(irq_take_o, 1'b1);
		irq_enable_i = 1'b0;
		fiq_enable_i = 1'b0;
		fiq_raise_i = 1'b1;
		step(0);
		fiq_raise_i = 1'b0;
		step(8);
		check_bit(irq_take_o, 1'b0);
		check_bit(fiq_take_o, 1'b0);
		// Clock relation select is ignored in the high-speed mode.
		sync_sel_i = 1'b1;
		step(4);
		check_bit(sync_mode_o, 1'b1);
		high_speed_i = 1'b1;
		sync_sel_i = 1'b0;
		step(4);
		check_bit(sync_mode_o, 1'b1);
		high_speed_i = 1'b0;
		step(4);
		check_bit(sync_mode_o, 1'b0);
		// Core reset with the address latch held, then a read after release.
		latch_en_i = 1'b0;
		sys_reset_req_i = 1'b1;
		step(2);
		sys_reset_req_i = 1'b0;
		step(1);
		check_bit(reset_active_o, 1'b1);
		check_bit(units_enable_o, 1'b0);
		check_data({29'h0, test_seen_o}, 32'h0);
		step(8);
		latch_en_i = 1'b1;
		step(2);
		check_data(bus_if.address, RESET_ADDR);
		do_acc(ACC_READ, 1'b0, 32'h3c, 32'h0);
		check_data(rd_data_o, model_q[15]);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
